// ==== src/tmw_pkg.sv ====
package tmw_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam int NUM_AB = 2;
  localparam int NUM_FLAGS = 5;

  // Register word addresses
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_AB = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_COUNTER = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_GR_A = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_GR_B = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_RUN = 3'h6;

  // Status and enable byte layout
  localparam int OVF_BIT = 7;
  localparam logic [7:0] RSVD_STATUS = 8'h70;
  localparam logic [7:0] RSVD_IRQ_EN = 8'h70;
  localparam int FLAG_OVF = 4;

  // Channel A/B control byte layout
  localparam logic [7:0] RSVD_CTRL_AB = 8'h88;
  localparam int B_MODE_BIT = 6;
  localparam int B_ACT_LSB = 4;
  localparam int A_MODE_BIT = 2;
  localparam int A_ACT_LSB = 0;
  localparam int RUN_BIT = 0;

  // Reset values
  localparam logic [CNT_W-1:0] COUNTER_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] COUNTER_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] GR_RESET = 16'hffff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] EN_RESET = 5'h00;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } tmw_action_t;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_BOTH_ALT = 2'b11
  } tmw_edge_t;

  typedef struct packed {
    logic capture;
    logic [1:0] action;
  } tmw_chan_cfg_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pin;
    logic event_hit;
    logic [CNT_W-1:0] gr;
  } tmw_chan_st_t;

  typedef struct packed {
    logic [CNT_W-1:0] counter;
    logic run;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] armed;
    logic [7:0] ctrl;
    logic [NUM_FLAGS-1:0] irq_en;
    logic [DATA_W-1:0] rdata;
    logic [NUM_FLAGS-1:0] irq;
  } tmw_top_st_t;

endpackage : tmw_pkg

// ==== src/tmw_chan.sv ====
`timescale 1ns/1ps
`default_nettype none

module tmw_chan
  import tmw_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire tmw_chan_cfg_t i_cfg,
  input wire logic i_tick,
  input wire logic [CNT_W-1:0] i_counter,
  input wire logic i_gr_wr,
  input wire logic [CNT_W-1:0] i_gr_wdata,
  input wire logic i_pin,
  output logic [CNT_W-1:0] o_gr,
  output logic o_event,
  output logic o_pin,
  output logic o_pin_oe
);

  tmw_chan_st_t st_q;
  tmw_chan_st_t st_d;
  logic rise;
  logic fall;
  logic edge_hit;

  always_comb begin
    st_d = st_q;
    st_d.sync1 = i_pin;
    st_d.sync2 = st_q.sync1;
    st_d.prev = st_q.sync2;
    st_d.event_hit = 1'b0;
    rise = st_q.sync2 & ~st_q.prev;
    fall = ~st_q.sync2 & st_q.prev;
    case (tmw_edge_t'(i_cfg.action))
      EDGE_RISE: edge_hit = rise; // see RQ12 see RQ13
      EDGE_FALL: edge_hit = fall;
      default: edge_hit = rise | fall;
    endcase
    if (i_gr_wr) begin
      st_d.gr = i_gr_wdata;
    end
    if (i_cfg.capture) begin
      // Capture wins over a software write in the same cycle
      if (edge_hit) begin
        st_d.gr = i_counter; // see RQ5
        st_d.event_hit = 1'b1;
      end
    end else if (i_tick && (i_counter == st_q.gr)) begin
      st_d.event_hit = 1'b1; // see RQ4
      case (tmw_action_t'(i_cfg.action))
        ACT_NONE: st_d.pin = st_q.pin; // see RQ10 see RQ11
        ACT_LOW: st_d.pin = 1'b0;
        ACT_HIGH: st_d.pin = 1'b1;
        ACT_TOGGLE: st_d.pin = ~st_q.pin;
        default: st_d.pin = st_q.pin;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      st_q <= '{sync1: 1'b0, sync2: 1'b0, prev: 1'b0, pin: 1'b0,
                event_hit: 1'b0, gr: GR_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_gr = st_q.gr;
  assign o_event = st_q.event_hit;
  assign o_pin = st_q.pin;
  assign o_pin_oe = ~i_cfg.capture; // see RQ8 see RQ9

endmodule : tmw_chan

`default_nettype wire

// ==== src/tmw_timer_status_ab.sv ====
// Functional notes
// RQ1 - Counter wrap to zero sets overflow flag
// RQ2 - Overflow clears by read-at-one then write zero
// RQ3 - Status bits 6..4 always read one
// RQ4 - Compare-mode match sets channel event flag
// RQ5 - Capture-mode capture sets channel event flag
// RQ6 - Channel flags clear by read-at-one, write zero
// RQ7 - Control bits 7 and 3 read one
// RQ8 - Control bit 6 selects B compare/capture
// RQ9 - Control bit 2 selects A compare/capture
// RQ10 - B action bits 5:4 set pin on match
// RQ11 - A action bits 1:0 set pin on match
// RQ12 - B action field selects capture edge
// RQ13 - A action field selects capture edge
// RQ14 - Control field positions B6, B5:4, A2, A1:0
// RQ15 - Overflow request when flag and enable set
// RQ16 - Channel request when flag and enable set
// RQ17 - Writing one leaves flags unchanged
// RQ18 - Set event beats simultaneous clearing write
`timescale 1ns/1ps
`default_nettype none

module tmw_timer_status_ab
  import tmw_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_chan_a_pin,
  output logic o_chan_a_pin,
  output logic o_chan_a_pin_oe,
  input wire logic i_chan_b_pin,
  output logic o_chan_b_pin,
  output logic o_chan_b_pin_oe,
  input wire logic i_chan_c_event,
  input wire logic i_chan_d_event,
  output logic o_overflow_irq,
  output logic [3:0] o_chan_irq
);

  tmw_top_st_t st_q;
  tmw_top_st_t st_d;

  tmw_chan_cfg_t cfg [NUM_AB];
  logic [NUM_AB-1:0] gr_wr;
  logic [NUM_AB-1:0] pin_in;
  logic [NUM_AB-1:0] pin_out;
  logic [NUM_AB-1:0] pin_oe;
  logic [NUM_AB-1:0] ch_event;
  logic [CNT_W-1:0] gr_val [NUM_AB];

  logic [7:0] status_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] en_byte;
  logic [NUM_FLAGS-1:0] set_vec;
  logic [NUM_FLAGS-1:0] wr_bits;
  logic [NUM_FLAGS-1:0] clr_vec;
  logic status_wr;
  logic counter_wr;
  logic wrap;

  assign pin_in = {i_chan_b_pin, i_chan_a_pin};

  // Field placement of the A/B control byte
  assign cfg[0] = '{capture: st_q.ctrl[A_MODE_BIT],
                    action: st_q.ctrl[A_ACT_LSB+1:A_ACT_LSB]}; // see RQ14
  assign cfg[1] = '{capture: st_q.ctrl[B_MODE_BIT],
                    action: st_q.ctrl[B_ACT_LSB+1:B_ACT_LSB]}; // see RQ14

  assign gr_wr[0] = i_wr && (i_addr == ADDR_GR_A);
  assign gr_wr[1] = i_wr && (i_addr == ADDR_GR_B);

  genvar g;
  generate
    for (g = 0; g < NUM_AB; g++) begin : g_chan
      tmw_chan u_chan (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_cfg(cfg[g]),
        .i_tick(st_q.run),
        .i_counter(st_q.counter),
        .i_gr_wr(gr_wr[g]),
        .i_gr_wdata(i_wdata[CNT_W-1:0]),
        .i_pin(pin_in[g]),
        .o_gr(gr_val[g]),
        .o_event(ch_event[g]),
        .o_pin(pin_out[g]),
        .o_pin_oe(pin_oe[g])
      );
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    status_byte = {st_q.flags[FLAG_OVF], 3'b000, st_q.flags[3:0]} | RSVD_STATUS; // see RQ3
    ctrl_byte = st_q.ctrl | RSVD_CTRL_AB; // see RQ7
    en_byte = {st_q.irq_en[FLAG_OVF], 3'b000, st_q.irq_en[3:0]} | RSVD_IRQ_EN;
    status_wr = i_wr && (i_addr == ADDR_STATUS);
    counter_wr = i_wr && (i_addr == ADDR_COUNTER);

    // Free counter; a software write suppresses the wrap of that cycle
    wrap = st_q.run && (st_q.counter == COUNTER_MAX) && !counter_wr;
    if (counter_wr) begin
      st_d.counter = i_wdata[CNT_W-1:0];
    end else if (st_q.run) begin
      st_d.counter = st_q.counter + 16'h0001;
    end

    set_vec = {wrap, i_chan_d_event, i_chan_c_event, ch_event}; // see RQ1 see RQ4 see RQ5

    // Only a zero written to an armed flag clears it; ones are ignored
    wr_bits = {i_wdata[OVF_BIT], i_wdata[3:0]};
    clr_vec = {NUM_FLAGS{status_wr}} & ~wr_bits & st_q.armed; // see RQ2 see RQ6 see RQ17
    st_d.flags = set_vec | (st_q.flags & ~clr_vec); // see RQ18

    // Arming needs a read that saw the flag at one; any status write consumes it
    if (status_wr) begin
      st_d.armed = '0;
    end else if (i_rd && (i_addr == ADDR_STATUS)) begin
      st_d.armed = st_q.armed | st_q.flags; // see RQ2 see RQ6
    end
    st_d.armed = st_d.armed & st_d.flags;

    if (i_wr) begin
      case (i_addr)
        ADDR_CTRL_AB: st_d.ctrl = i_wdata[7:0] & ~RSVD_CTRL_AB; // see RQ8 see RQ9
        ADDR_IRQ_EN: st_d.irq_en = {i_wdata[OVF_BIT], i_wdata[3:0]};
        ADDR_RUN: st_d.run = i_wdata[RUN_BIT];
        default: st_d.run = st_q.run;
      endcase
    end

    st_d.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        ADDR_STATUS: st_d.rdata = {8'h00, status_byte};
        ADDR_CTRL_AB: st_d.rdata = {8'h00, ctrl_byte};
        ADDR_IRQ_EN: st_d.rdata = {8'h00, en_byte};
        ADDR_COUNTER: st_d.rdata = st_q.counter;
        ADDR_GR_A: st_d.rdata = gr_val[0];
        ADDR_GR_B: st_d.rdata = gr_val[1];
        ADDR_RUN: st_d.rdata = {15'h0000, st_q.run};
        default: st_d.rdata = '0;
      endcase
    end

    // Requests follow the flag and enable of the same edge
    st_d.irq = st_d.flags & st_d.irq_en; // see RQ15 see RQ16
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      st_q <= '{counter: COUNTER_RESET, run: 1'b0, flags: '0, armed: '0,
                ctrl: CTRL_RESET, irq_en: EN_RESET, rdata: '0, irq: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;
  assign o_chan_a_pin = pin_out[0];
  assign o_chan_a_pin_oe = pin_oe[0];
  assign o_chan_b_pin = pin_out[1];
  assign o_chan_b_pin_oe = pin_oe[1];
  assign o_overflow_irq = st_q.irq[FLAG_OVF];
  assign o_chan_irq = st_q.irq[3:0];

endmodule : tmw_timer_status_ab

`default_nettype wire

// ==== sim/tmw_chk_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmw_chk
  import tmw_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic o_chan_a_pin_oe,
  input wire logic o_chan_b_pin_oe,
  input wire logic o_overflow_irq,
  input wire logic [3:0] o_chan_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_status_rsvd: assert property ($past(i_rd) && $past(i_addr) == ADDR_STATUS
    |-> o_rdata[6:4] == 3'h7) else $error("status reserved bits not one");
  a_ctrl_rsvd: assert property ($past(i_rd) && $past(i_addr) == ADDR_CTRL_AB
    |-> o_rdata[7] && o_rdata[3]) else $error("control reserved bits not one");
  a_mode_a: assert property ($past(i_rd) && $past(i_addr) == ADDR_CTRL_AB
    |-> o_rdata[A_MODE_BIT] == !$past(o_chan_a_pin_oe)) else $error("A drive vs mode");
  a_mode_b: assert property ($past(i_rd) && $past(i_addr) == ADDR_CTRL_AB
    |-> o_rdata[B_MODE_BIT] == !$past(o_chan_b_pin_oe)) else $error("B drive vs mode");
  a_ovf_irq: assert property ($past(i_rd) && $past(i_addr) == ADDR_STATUS
    && $past(o_overflow_irq) |-> o_rdata[OVF_BIT]) else $error("overflow request no flag");
  a_chan_irq: assert property ($past(i_rd) && $past(i_addr) == ADDR_STATUS
    |-> ($past(o_chan_irq) & ~o_rdata[3:0]) == 4'h0) else $error("channel request no flag");
  a_ones_keep: assert property ($past(i_wr) && $past(i_addr) == ADDR_STATUS
    && ($past(i_wdata) & 16'h000f) == 16'h000f
    |-> (o_chan_irq & $past(o_chan_irq)) == $past(o_chan_irq)) else $error("ones cleared");
endmodule : tmw_chk
bind tmw_timer_status_ab tmw_chk u_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_chan_a_pin_oe(o_chan_a_pin_oe), .o_chan_b_pin_oe(o_chan_b_pin_oe),
  .o_overflow_irq(o_overflow_irq), .o_chan_irq(o_chan_irq));
`default_nettype wire

// ==== sim/tmw_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmw_pin_model (
  input wire logic i_level,
  input wire logic i_dut_pin,
  input wire logic i_dut_oe,
  output logic o_wire
);
  // The device wins while it drives; otherwise the outside source sets the level
  assign o_wire = i_dut_oe ? i_dut_pin : i_level;
endmodule : tmw_pin_model
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tmw_pkg::*;
  logic clk, rst_n, wr, rd, ev_c, ev_d, ext_a, ext_b, qa, qb, oea, oeb, ovf_irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] chan_irq;
  wire logic pa, pb;
  int n_checks = 0;
  int n_mismatch = 0;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  tmw_timer_status_ab dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_chan_a_pin(pa),
    .o_chan_a_pin(qa), .o_chan_a_pin_oe(oea), .i_chan_b_pin(pb), .o_chan_b_pin(qb),
    .o_chan_b_pin_oe(oeb), .i_chan_c_event(ev_c), .i_chan_d_event(ev_d),
    .o_overflow_irq(ovf_irq), .o_chan_irq(chan_irq));
  tmw_pin_model u_pa (.i_level(ext_a), .i_dut_pin(qa), .i_dut_oe(oea), .o_wire(pa));
  tmw_pin_model u_pb (.i_level(ext_b), .i_dut_pin(qb), .i_dut_oe(oeb), .o_wire(pb));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rreg
  task automatic t_regs;
    rreg(ADDR_STATUS, 16'h0070);
    rreg(ADDR_CTRL_AB, 16'h0088);
    wreg(ADDR_CTRL_AB, 16'hffff);
    rreg(ADDR_CTRL_AB, 16'h00ff);
    wreg(3'h7, 16'hffff);
    rreg(3'h7, 16'h0000);
    idle(2);
    chk(oea, 1'b0);
  endtask : t_regs
  task automatic t_cmp;
    wreg(ADDR_GR_A, 16'h0010);
    wreg(ADDR_GR_B, 16'h0012);
    wreg(ADDR_IRQ_EN, 16'h0003);
    wreg(ADDR_CTRL_AB, 16'h0023);
    wreg(ADDR_RUN, 16'h0001);
    idle(40);
    wreg(ADDR_RUN, 16'h0000);
    rreg(ADDR_STATUS, 16'h0073);
    chk(qa, 1'b1);
    chk(qb, 1'b1);
    chk(chan_irq, 4'h3);
  endtask : t_cmp
  task automatic t_clr;
    wreg(ADDR_STATUS, 16'h00ff);
    wreg(ADDR_STATUS, 16'h0000);
    rreg(ADDR_STATUS, 16'h0073);
    wreg(ADDR_STATUS, 16'h0002);
    rreg(ADDR_STATUS, 16'h0072);
    wreg(ADDR_STATUS, 16'h0000);
    idle(2);
    chk(chan_irq, 4'h0);
  endtask : t_clr
  task automatic t_cap;
    wreg(ADDR_CTRL_AB, 16'h0056);
    idle(4);
    chk(oeb, 1'b0);
    // Handing the pins to the outside drops both from one to zero, a real edge
    rreg(ADDR_STATUS, 16'h0073);
    wreg(ADDR_STATUS, 16'h0000);
    wreg(ADDR_COUNTER, 16'h1234);
    ext_a <= 1'b1;
    ext_b <= 1'b1;
    idle(8);
    rreg(ADDR_STATUS, 16'h0071);
    ext_b <= 1'b0;
    idle(8);
    rreg(ADDR_STATUS, 16'h0073);
    rreg(ADDR_GR_B, 16'h1234);
    rreg(ADDR_GR_A, 16'h1234);
    wreg(ADDR_STATUS, 16'h0000);
    wreg(ADDR_CTRL_AB, 16'h0046);
    wreg(ADDR_COUNTER, 16'h4321);
    ext_b <= 1'b1;
    idle(8);
    rreg(ADDR_STATUS, 16'h0072);
    rreg(ADDR_GR_B, 16'h4321);
    wreg(ADDR_STATUS, 16'h0000);
  endtask : t_cap
  task automatic t_ovf;
    wreg(ADDR_GR_A, 16'h0001);
    wreg(ADDR_GR_B, 16'h0001);
    wreg(ADDR_CTRL_AB, 16'h0001);
    wreg(ADDR_IRQ_EN, 16'h008c);
    wreg(ADDR_COUNTER, 16'hfffe);
    ev_c <= 1'b1;
    @(posedge clk);
    ev_c <= 1'b0;
    ev_d <= 1'b1;
    @(posedge clk);
    ev_d <= 1'b0;
    wreg(ADDR_RUN, 16'h0001);
    idle(4);
    wreg(ADDR_RUN, 16'h0000);
    rreg(ADDR_STATUS, 16'h00ff);
    chk(qa, 1'b0);
    chk(qb, 1'b1);
    chk(ovf_irq, 1'b1);
    chk(chan_irq, 4'hc);
    wreg(ADDR_STATUS, 16'h0000);
    idle(2);
    chk(ovf_irq, 1'b0);
  endtask : t_ovf
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {rst_n, wr, rd, ev_c, ev_d, ext_a, ext_b} = '0;
    addr = '0;
    wdata = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_cmp();
    t_clr();
    t_cap();
    t_ovf();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
